// ---- afsp_pkg.sv ----
package afsp_pkg;

    // ************************************************************
    // Word and mode encodings
    // ************************************************************
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] WORD_LEN = 5'h10;
    localparam logic [4:0] LAST_BIT = 5'h0f;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [1:0] PAIR_ZERO = 2'h0;

    typedef enum logic [1:0] {
        AFSP_MODE_WIRE = 2'b00,
        AFSP_MODE_EDGE = 2'b01,
        AFSP_MODE_GATED = 2'b10,
        AFSP_MODE_CONT = 2'b11
    } afsp_mode_t;

    typedef enum logic [1:0] {
        AFSP_MS_IDLE = 2'b00,
        AFSP_MS_WAIT = 2'b01,
        AFSP_MS_XFER = 2'b10
    } afsp_mstate_t;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam longint CLK_SYS_HZ = 20_000_000;
    localparam longint CLK_SYS_NS = 50;
    // Frame sync delay after start, in halves of a master clock period
    localparam int FS_DELAY_HALVES = 5;
    localparam logic [1:0] FS_DELAY_CYCLES = 2'((FS_DELAY_HALVES + 1) / 2);
    localparam logic [1:0] FS_DELAY_DONE = 2'h1;
    // Power-up calibration time
    localparam longint CAL_TIME_MS = 42;
    localparam int CAL_CYCLES = int'(CLK_SYS_HZ / 1000 * CAL_TIME_MS);
    localparam int CAL_W = 20;
    // Conversion length for the externally clocked modes
    localparam longint CONV_TIME_NS = 3250;
    localparam int CONV_CYCLES = int'(CONV_TIME_NS / CLK_SYS_NS);
    localparam int CONV_W = 8;

endpackage

// ---- afsp_top.sv ----
`timescale 1ns/1ps
//Contract
//R1: Edge mode: sync fall starts 16 counted bits
//R2: Host may raise sync anytime after start; code allows this in edge mode only, wire mode clears the count
//R3: Edge mode: output off while sync high
//R4: Edge mode: input sampled on rising clock
//R5: Polarity pin swaps sample and launch edges
//R6: Host resyncs by sync high then low
//R7: Self-clock modes drive clock and sync
//R8: Serial clock suppressed during calibration
//R9: Current result out, written word for next
//R10: Convert-start fall begins conversion, busy high
//R11: Convert-start rise drops sync after delay
//R12: After 16 clocks sync rises, busy falls
//R13: Host waits 330 ns after busy falls
//R14: First bit at sync fall, rest rising
//R15: Self-clock modes capture input on rising edge
//R16: Sync rises after 16th rising edge
//R17: Software start bit starts conversion and frame
//R18: Frames start only by pin rise or software
//R19: Calibration runs after power-up, about 42 ms
//R20: Two-wire mode only by register select bit
//R21: Three-wire full duplex; zero word ignored
//R22: Busy status clears at conversion end
//R23: Mode pins select interface mode
//R24: Sync high clears input shift register; code does so mid-frame only in wire mode, edge mode keeps counting
//R25: Bits after the 16th are ignored
module afsp_top #(
    parameter int CAL_CYCLES = afsp_pkg::CAL_CYCLES,
    parameter int CONV_CYCLES = afsp_pkg::CONV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic mode_select_hi,
    input wire logic mode_select_lo,
    input wire logic polarity,
    input wire logic two_wire_sel,
    input wire logic convert_start_n,
    input wire logic sw_convert_start,
    input wire logic [15:0] tx_word,
    input wire logic tx_load,
    input wire logic frame_sync_n_in,
    input wire logic din,
    output logic frame_sync_n_out,
    output logic frame_sync_oe,
    output logic sclk_gate,
    output logic sclk_oe,
    output logic dout,
    output logic dout_oe,
    output logic din_out,
    output logic din_oe,
    output logic [15:0] rx_word,
    output logic rx_strobe,
    output logic busy,
    output logic cal_active
);

    // ************************************************************
    // Link clocks
    // ************************************************************
    // Straps are static; swapping edges by inverting the clock keeps one code path
    logic strap_master;
    logic lclk;
    logic lclk_launch;
    assign strap_master = mode_select_hi;
    assign lclk = link_clk ^ polarity; // R5
    assign lclk_launch = lclk ^ ~strap_master; // R5 R14

    logic lrst_s1;
    logic lrst_n;
    always_ff @(posedge lclk or negedge arst_n) begin
        if (!arst_n) begin
            lrst_s1 <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            lrst_n <= lrst_s1;
        end
    end

    // ************************************************************
    // System domain: synchronisers
    // ************************************************************
    logic [1:0] mode_s1, mode_s;
    logic cs_s1, cs_s, cs_prev;
    logic rxt_s1, rxt_s, rxt_prev;
    logic dnt_s1, dnt_s, dnt_prev;
    logic rx_tgl, done_tgl;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_s1 <= afsp_pkg::PAIR_ZERO;
            mode_s <= afsp_pkg::PAIR_ZERO;
            cs_s1 <= 1'b1;
            cs_s <= 1'b1;
            cs_prev <= 1'b1;
            rxt_s1 <= 1'b0;
            rxt_s <= 1'b0;
            rxt_prev <= 1'b0;
            dnt_s1 <= 1'b0;
            dnt_s <= 1'b0;
            dnt_prev <= 1'b0;
        end else begin
            mode_s1 <= {mode_select_hi, mode_select_lo}; // R23
            mode_s <= mode_s1;
            cs_s1 <= convert_start_n;
            cs_s <= cs_s1;
            cs_prev <= cs_s;
            rxt_s1 <= rx_tgl;
            rxt_s <= rxt_s1;
            rxt_prev <= rxt_s;
            dnt_s1 <= done_tgl;
            dnt_s <= dnt_s1;
            dnt_prev <= dnt_s;
        end
    end

    logic sys_master;
    logic cs_fall, cs_rise, rx_evt, done_evt;
    assign sys_master = mode_s[1];
    assign cs_fall = cs_prev & ~cs_s;
    assign cs_rise = ~cs_prev & cs_s;
    assign rx_evt = rxt_s ^ rxt_prev;
    assign done_evt = dnt_s ^ dnt_prev;

    // ************************************************************
    // System domain: conversion, calibration, words
    // ************************************************************
    logic [afsp_pkg::CAL_W-1:0] cal_cnt, next_cal_cnt;
    logic [afsp_pkg::CONV_W-1:0] conv_cnt, next_conv_cnt;
    logic next_busy, next_cal_active;
    logic start_tgl, next_start_tgl;
    logic [15:0] tx_hold, next_tx_hold;
    logic tx_tgl, next_tx_tgl;
    logic [15:0] next_rx_word;
    logic [15:0] rx_hold, next_rx_hold;
    logic next_rx_strobe;
    logic conv_begin;
    assign conv_begin = cs_fall | sw_convert_start; // R10 R17

    always_comb begin
        next_cal_cnt = cal_cnt;
        next_cal_active = cal_active;
        if (cal_active) begin
            if (cal_cnt == afsp_pkg::CAL_W'(CAL_CYCLES - 1)) begin
                next_cal_active = 1'b0; // R19
            end else begin
                next_cal_cnt = cal_cnt + 1'b1;
            end
        end
        next_conv_cnt = conv_cnt;
        next_busy = busy;
        // Conversions in externally clocked modes end on an internal count
        if (busy && !sys_master) begin
            next_conv_cnt = conv_cnt + 1'b1;
            if (conv_cnt == afsp_pkg::CONV_W'(CONV_CYCLES - 1)) begin
                next_busy = 1'b0; // R22
            end
        end
        if (done_evt && sys_master) begin
            next_busy = 1'b0; // R12 R22
        end
        if (conv_begin) begin
            next_busy = 1'b1; // R10 R17
            next_conv_cnt = '0;
        end
        next_start_tgl = start_tgl;
        if (sys_master && (cs_rise || sw_convert_start)) begin
            next_start_tgl = ~start_tgl; // R11 R17 R18
        end
        next_tx_hold = tx_hold;
        next_tx_tgl = tx_tgl;
        if (tx_load) begin
            next_tx_hold = tx_word;
            next_tx_tgl = ~tx_tgl;
        end
        next_rx_word = rx_word;
        next_rx_strobe = 1'b0;
        if (rx_evt) begin
            next_rx_word = rx_hold; // R9
            next_rx_strobe = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cal_cnt <= '0;
            cal_active <= 1'b1;
            conv_cnt <= '0;
            busy <= 1'b0;
            start_tgl <= 1'b0;
            tx_hold <= afsp_pkg::WORD_ZERO;
            tx_tgl <= 1'b0;
            rx_word <= afsp_pkg::WORD_ZERO;
            rx_strobe <= 1'b0;
        end else begin
            cal_cnt <= next_cal_cnt;
            cal_active <= next_cal_active;
            conv_cnt <= next_conv_cnt;
            busy <= next_busy;
            start_tgl <= next_start_tgl;
            tx_hold <= next_tx_hold;
            tx_tgl <= next_tx_tgl;
            rx_word <= next_rx_word;
            rx_strobe <= next_rx_strobe;
        end
    end

    // ************************************************************
    // Link domain: crossings in
    // ************************************************************
    logic st_s1, st_s, st_prev, tt_s1, tt_s, tt_prev, cal_s1, cal_l;
    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            st_s1 <= 1'b0;
            st_s <= 1'b0;
            st_prev <= 1'b0;
            tt_s1 <= 1'b0;
            tt_s <= 1'b0;
            tt_prev <= 1'b0;
            cal_s1 <= 1'b1;
            cal_l <= 1'b1;
        end else begin
            st_s1 <= start_tgl;
            st_s <= st_s1;
            st_prev <= st_s;
            tt_s1 <= tx_tgl;
            tt_s <= tt_s1;
            tt_prev <= tt_s;
            cal_s1 <= cal_active;
            cal_l <= cal_s1;
        end
    end

    // ************************************************************
    // Link domain: sampling edge and frame control
    // ************************************************************
    afsp_pkg::afsp_mstate_t mst, next_mst;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [15:0] rx_shift, next_rx_shift;
    logic [15:0] tx_link, next_tx_link;
    logic [1:0] dly, next_dly;
    logic sync_prev, tw_send, next_tw_send;
    logic next_rx_tgl, next_done_tgl, next_fs, next_gate;
    logic [15:0] word_in;
    logic lnk_edge, lnk_wire, lnk_two;
    assign lnk_edge = ~mode_select_hi & mode_select_lo;
    assign lnk_wire = ~mode_select_hi & ~mode_select_lo;
    assign lnk_two = lnk_wire & two_wire_sel; // R20
    assign word_in = {rx_shift[14:0], lnk_two ? din : din};

    always_comb begin
        next_mst = mst;
        next_bit_cnt = bit_cnt;
        next_rx_shift = rx_shift;
        next_rx_hold = rx_hold;
        next_rx_tgl = rx_tgl;
        next_done_tgl = done_tgl;
        next_dly = dly;
        next_fs = frame_sync_n_out;
        next_tw_send = tw_send;
        next_tx_link = (tt_s ^ tt_prev) ? tx_hold : tx_link;
        if (strap_master) begin
            unique case (mst)
                afsp_pkg::AFSP_MS_IDLE: begin
                    if (st_s ^ st_prev) begin
                        next_mst = afsp_pkg::AFSP_MS_WAIT; // R18
                        next_dly = afsp_pkg::FS_DELAY_CYCLES;
                    end
                end
                afsp_pkg::AFSP_MS_WAIT: begin
                    next_dly = dly - 1'b1;
                    if (dly == afsp_pkg::FS_DELAY_DONE) begin
                        next_mst = afsp_pkg::AFSP_MS_XFER;
                        next_fs = 1'b0; // R11
                        next_bit_cnt = afsp_pkg::CNT_ZERO;
                        next_rx_shift = afsp_pkg::WORD_ZERO;
                    end
                end
                afsp_pkg::AFSP_MS_XFER: begin
                    if (!cal_l) begin
                        next_rx_shift = word_in; // R15
                        next_bit_cnt = bit_cnt + 1'b1;
                        if (bit_cnt == afsp_pkg::LAST_BIT) begin
                            next_fs = 1'b1; // R12 R16
                            next_mst = afsp_pkg::AFSP_MS_IDLE;
                            next_done_tgl = ~done_tgl;
                            if (word_in != afsp_pkg::WORD_ZERO) begin
                                next_rx_hold = word_in; // R9 R21
                                next_rx_tgl = ~rx_tgl;
                            end
                        end
                    end
                end
                default: next_mst = afsp_pkg::AFSP_MS_IDLE;
            endcase
        end else begin
            next_mst = afsp_pkg::AFSP_MS_IDLE;
            next_fs = 1'b1;
            if (frame_sync_n_in && (lnk_wire || bit_cnt == afsp_pkg::CNT_ZERO
                    || bit_cnt == afsp_pkg::WORD_LEN)) begin
                next_rx_shift = afsp_pkg::WORD_ZERO; // R24
                next_bit_cnt = afsp_pkg::CNT_ZERO;
            end
            if (!frame_sync_n_in && lnk_edge && sync_prev) begin
                next_rx_shift = {afsp_pkg::WORD_ZERO[14:0], din}; // R1 R4 R6
                next_bit_cnt = afsp_pkg::CNT_ONE;
            end else if ((lnk_edge || !frame_sync_n_in)
                    && bit_cnt != afsp_pkg::CNT_ZERO
                    && bit_cnt != afsp_pkg::WORD_LEN) begin
                next_rx_shift = word_in; // R1 R2 R4
                next_bit_cnt = bit_cnt + 1'b1;
            end else if (lnk_wire && !frame_sync_n_in
                    && bit_cnt == afsp_pkg::CNT_ZERO) begin
                next_rx_shift = word_in; // R4
                next_bit_cnt = afsp_pkg::CNT_ONE;
            end
            if (next_bit_cnt == afsp_pkg::WORD_LEN && bit_cnt == afsp_pkg::LAST_BIT) begin
                if (lnk_two) begin
                    next_tw_send = ~tw_send; // R20
                end
                if (!(lnk_two && tw_send) && word_in != afsp_pkg::WORD_ZERO) begin
                    next_rx_hold = word_in; // R21
                    next_rx_tgl = ~rx_tgl;
                end
            end
        end
        // Mode 2 gates the clock with frame sync, mode 3 runs it free
        next_gate = strap_master & ~cal_l & (mode_select_lo | ~next_fs); // R7 R8
    end

    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            mst <= afsp_pkg::AFSP_MS_IDLE;
            bit_cnt <= afsp_pkg::CNT_ZERO;
            rx_shift <= afsp_pkg::WORD_ZERO;
            rx_hold <= afsp_pkg::WORD_ZERO;
            tx_link <= afsp_pkg::WORD_ZERO;
            rx_tgl <= 1'b0;
            done_tgl <= 1'b0;
            dly <= afsp_pkg::FS_DELAY_CYCLES;
            sync_prev <= 1'b1;
            tw_send <= 1'b0;
            frame_sync_n_out <= 1'b1;
            frame_sync_oe <= 1'b0;
            sclk_gate <= 1'b0;
            sclk_oe <= 1'b0;
        end else begin
            mst <= next_mst;
            bit_cnt <= next_bit_cnt;
            rx_shift <= next_rx_shift;
            rx_hold <= next_rx_hold;
            tx_link <= next_tx_link;
            rx_tgl <= next_rx_tgl;
            done_tgl <= next_done_tgl;
            dly <= next_dly;
            sync_prev <= frame_sync_n_in;
            tw_send <= next_tw_send;
            frame_sync_n_out <= next_fs;
            frame_sync_oe <= strap_master; // R7
            sclk_gate <= next_gate;
            sclk_oe <= strap_master; // R7
        end
    end

    // ************************************************************
    // Link domain: launch edge
    // ************************************************************
    logic [15:0] tx_shift, next_tx_shift;
    logic [4:0] tx_cnt, next_tx_cnt;
    logic next_dout, next_oe, next_io_oe, sync_lo;
    assign sync_lo = strap_master ? 1'b0 : ~frame_sync_n_in;

    always_comb begin
        next_tx_shift = tx_shift;
        next_tx_cnt = tx_cnt;
        next_dout = dout;
        next_oe = 1'b0;
        next_io_oe = 1'b0;
        if (strap_master) begin
            next_oe = 1'b1;
            if (mst == afsp_pkg::AFSP_MS_WAIT && dly == afsp_pkg::FS_DELAY_DONE) begin
                next_dout = tx_link[15]; // R14
                next_tx_shift = {tx_link[14:0], 1'b0};
            end else if (mst == afsp_pkg::AFSP_MS_XFER && !cal_l) begin
                next_dout = tx_shift[15]; // R14 R9
                next_tx_shift = {tx_shift[14:0], 1'b0};
            end
        end else if (!sync_lo) begin
            next_tx_shift = tx_link; // R3
            next_tx_cnt = afsp_pkg::CNT_ZERO;
        end else begin
            next_oe = ~lnk_two; // R3 R21
            // Send flag flips half a cycle before the last bit leaves
            next_io_oe = lnk_two & (tw_send ^ (tx_cnt == afsp_pkg::LAST_BIT)); // R20
            if (tx_cnt != afsp_pkg::WORD_LEN) begin
                next_dout = tx_shift[15]; // R3 R25
                next_tx_shift = {tx_shift[14:0], 1'b0};
                next_tx_cnt = tx_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge lclk_launch or negedge lrst_n) begin
        if (!lrst_n) begin
            tx_shift <= afsp_pkg::WORD_ZERO;
            tx_cnt <= afsp_pkg::CNT_ZERO;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            din_out <= 1'b0;
            din_oe <= 1'b0;
        end else begin
            tx_shift <= next_tx_shift;
            tx_cnt <= next_tx_cnt;
            dout <= next_dout;
            dout_oe <= next_oe;
            din_out <= next_dout;
            din_oe <= next_io_oe;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence frame_open_s;
        mst == afsp_pkg::AFSP_MS_WAIT && dly == afsp_pkg::FS_DELAY_DONE;
    endsequence
    sequence last_bit_s;
        mst == afsp_pkg::AFSP_MS_XFER && bit_cnt == afsp_pkg::LAST_BIT && !cal_l;
    endsequence

    conv_busy_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
        cs_fall |=> busy) else $error("busy not raised by convert start");
    sw_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R17
        sw_convert_start && sys_master |=> busy && (start_tgl != $past(start_tgl)))
        else $error("software start did not open a frame");
    busy_end_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
        done_evt && sys_master && !conv_begin |=> !busy) else $error("busy not cleared");
    cal_end_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R19
        $fell(cal_active) |-> $past(cal_cnt) == afsp_pkg::CAL_W'(CAL_CYCLES - 1))
        else $error("calibration ended early");
    rx_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R21
        rx_strobe |-> rx_word != afsp_pkg::WORD_ZERO) else $error("zero word delivered");
    sync_fall_a: assert property (@(posedge lclk) disable iff (!lrst_n) // R11
        frame_open_s |=> !frame_sync_n_out ##1 !frame_sync_n_out)
        else $error("frame sync did not fall");
    frame_end_a: assert property (@(posedge lclk) disable iff (!lrst_n) // R16
        last_bit_s |=> frame_sync_n_out && mst == afsp_pkg::AFSP_MS_IDLE)
        else $error("frame sync not raised after 16 bits");
    cal_gate_a: assert property (@(posedge lclk) disable iff (!lrst_n) // R8
        cal_l |=> !sclk_gate) else $error("serial clock runs during calibration");
    count_cap_a: assert property (@(posedge lclk) disable iff (!lrst_n) // R25
        bit_cnt <= afsp_pkg::WORD_LEN) else $error("bit count past word");
    dout_off_a: assert property (@(posedge lclk_launch) disable iff (!lrst_n) // R3
        !strap_master && frame_sync_n_in |=> !dout_oe) else $error("output not released");

endmodule // afsp_top

// ---- afsp_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Serial port of the host processor
// ****************************************
module afsp_host_model (
    input wire logic link_clk,
    input wire logic master,
    input wire logic go,
    input wire logic [15:0] host_tx,
    input wire logic frame_sync_n_out,
    input wire logic sclk_gate,
    input wire logic dout,
    output logic frame_sync_n_in,
    output logic din,
    output logic [15:0] host_rx,
    output logic host_done
);
    int sc, mc, rc;
    initial begin
        frame_sync_n_in = 1'b1;
        din = 1'b0;
        host_rx = 16'h0000;
        {sc, mc, rc} = '0;
    end
    assign host_done = go && (master ? (mc == 16 && frame_sync_n_out) : sc == 17);
    // Idle data toggles so a stale bit never passes for a good one
    always @(negedge link_clk) begin
        if (master) begin
            if (!go) begin
                mc <= 0;
                din <= ~din;
            end else if (!frame_sync_n_out && sclk_gate && mc < 16) begin
                host_rx <= {host_rx[14:0], dout};
                din <= host_tx[15 - mc];
                mc <= mc + 1;
            end else begin
                din <= ~din;
            end
        end else if (!go || sc >= 16) begin
            frame_sync_n_in <= 1'b1;
            din <= ~din;
            sc <= go ? 17 : 0;
        end else begin
            frame_sync_n_in <= 1'b0;
            din <= host_tx[15 - sc];
            sc <= sc + 1;
        end
    end
    always @(posedge link_clk) begin
        if (!go) begin
            rc <= 0;
        end else if (!master && sc >= 2 && rc < 16) begin
            host_rx <= {host_rx[14:0], dout};
            rc <= rc + 1;
        end
    end
endmodule // afsp_host_model

// ---- afsp_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module afsp_bench;
    typedef struct {
        afsp_pkg::afsp_mode_t mode;
        logic [15:0] din;
        logic [15:0] tx;
        logic strb;
    } afsp_row_t;
    afsp_row_t rows [5] = '{
        '{afsp_pkg::AFSP_MODE_EDGE, 16'hA5C3, 16'h1234, 1'b1},
        '{afsp_pkg::AFSP_MODE_EDGE, 16'h0000, 16'h8001, 1'b0},
        '{afsp_pkg::AFSP_MODE_CONT, 16'h5A0F, 16'hC0DE, 1'b1},
        '{afsp_pkg::AFSP_MODE_GATED, 16'h0001, 16'hFFFE, 1'b1},
        '{afsp_pkg::AFSP_MODE_WIRE, 16'h7E81, 16'h3A5C, 1'b1}
    };
    logic clk_sys, arst_n, link_clk, mode_select_hi, mode_select_lo, convert_start_n;
    logic sw_convert_start, tx_load, go, strobe_seen, frame_sync_n_in, din;
    logic frame_sync_n_out, frame_sync_oe, sclk_gate, sclk_oe, dout, dout_oe;
    logic rx_strobe, busy, cal_active, host_done, polarity, two_wire_sel, din_out, din_oe;
    logic [15:0] tx_word, host_tx, host_rx, rx_word;
    int fails, cmp_count;

    afsp_top #(.CAL_CYCLES(20), .CONV_CYCLES(8)) i_afsp_top (
        .clk_sys(clk_sys), .arst_n(arst_n), .link_clk(link_clk),
        .mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
        .polarity(polarity), .two_wire_sel(two_wire_sel), .convert_start_n(convert_start_n),
        .sw_convert_start(sw_convert_start), .tx_word(tx_word), .tx_load(tx_load),
        .frame_sync_n_in(frame_sync_n_in), .din(din),
        .frame_sync_n_out(frame_sync_n_out), .frame_sync_oe(frame_sync_oe),
        .sclk_gate(sclk_gate), .sclk_oe(sclk_oe), .dout(dout), .dout_oe(dout_oe),
        .din_out(din_out), .din_oe(din_oe), .rx_word(rx_word), .rx_strobe(rx_strobe),
        .busy(busy), .cal_active(cal_active)
    );
    afsp_host_model i_afsp_host_model (
        .link_clk(link_clk ^ polarity), .master(mode_select_hi), .go(go), .host_tx(host_tx),
        .frame_sync_n_out(frame_sync_n_out), .sclk_gate(sclk_gate),
        .dout(two_wire_sel ? din_out : dout),
        .frame_sync_n_in(frame_sync_n_in), .din(din), .host_rx(host_rx),
        .host_done(host_done)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Link clock offset so its edges never line up with clk_sys
    initial begin
        link_clk = 1'b0;
        #7;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge clk_sys) if (rx_strobe === 1'b1) strobe_seen <= 1'b1;

    // ****************************************
    // Tasks
    // ****************************************
    task settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task test_done;
        $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Sel 0: calibration over, 1: host frame done, 2: busy low
    task wait_on(input int sel, input int lim);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(negedge clk_sys);
            ok = sel == 0 ? cal_active === 1'b0 : sel == 1 ? host_done === 1'b1 : busy === 1'b0;
        end
        if (!ok) begin
            `CHK(1'b0, 1'b1)
            test_done();
        end
    endtask
    // Straps only change under reset, so every case restarts the part
    task start(input afsp_pkg::afsp_mode_t m);
        {mode_select_hi, mode_select_lo} = m;
        go = 1'b0;
        arst_n = 1'b0;
        settle(2);
        arst_n = 1'b1;
        settle(1);
        `CHK(cal_active, 1'b1)
        `CHK(sclk_gate, 1'b0)
        wait_on(0, 60);
    endtask
    task load(input logic [15:0] t, input logic [15:0] h);
        tx_word = t;
        tx_load = 1'b1;
        settle(1);
        tx_load = 1'b0;
        host_tx = h;
        strobe_seen = 1'b0;
        // Word must reach the link side before the host opens a frame
        settle(8);
        go = 1'b1;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {arst_n, mode_select_hi, mode_select_lo, sw_convert_start, tx_load, go} = '0;
        {convert_start_n, strobe_seen, fails, cmp_count, polarity, two_wire_sel} = '0;
        convert_start_n = 1'b1;
        {tx_word, host_tx} = '0;
        foreach (rows[r]) begin
            start(rows[r].mode);
            load(rows[r].tx, rows[r].din);
            convert_start_n = 1'b0;
            settle(4);
            `CHK(busy, 1'b1)
            convert_start_n = 1'b1;
            wait_on(1, 400);
            wait_on(2, 100);
            settle(4);
            `CHK(strobe_seen, rows[r].strb)
            if (rows[r].strb) `CHK(rx_word, rows[r].din)
            `CHK(host_rx, rows[r].tx)
            if (mode_select_hi) begin
                `CHK(frame_sync_oe, 1'b1)
                `CHK(sclk_oe, 1'b1)
                `CHK(sclk_gate, mode_select_lo)
                `CHK(frame_sync_n_out, 1'b1)
            end else `CHK(dout_oe, 1'b0)
            go = 1'b0;
            settle(8);
        end
        two_wire_sel = 1'b1;
        start(afsp_pkg::AFSP_MODE_WIRE);
        load(16'h6B17, 16'h9C3A);
        wait_on(1, 400);
        settle(4);
        `CHK(rx_word, 16'h9C3A)
        go = 1'b0;
        settle(4);
        strobe_seen = 1'b0;
        go = 1'b1;
        settle(4);
        `CHK(din_oe, 1'b1)
        `CHK(dout_oe, 1'b0)
        wait_on(1, 400);
        settle(4);
        `CHK(host_rx, 16'h6B17)
        `CHK(strobe_seen, 1'b0)
        two_wire_sel = 1'b0;
        // Swapped link edges for the rest of the run
        polarity = 1'b1;
        start(afsp_pkg::AFSP_MODE_EDGE);
        load(16'h0000, 16'hFFFF);
        settle(10);
        go = 1'b0;
        settle(24);
        host_tx = 16'h3C96;
        go = 1'b1;
        wait_on(1, 400);
        settle(4);
        `CHK(rx_word, 16'h3C96)
        start(afsp_pkg::AFSP_MODE_CONT);
        load(16'h0F0F, 16'hE1E1);
        sw_convert_start = 1'b1;
        settle(1);
        sw_convert_start = 1'b0;
        settle(1);
        `CHK(busy, 1'b1)
        wait_on(1, 400);
        wait_on(2, 100);
        settle(4);
        `CHK(rx_word, 16'hE1E1)
        `CHK(host_rx, 16'h0F0F)
        go = 1'b0;
        settle(8);
        go = 1'b1;
        settle(80);
        `CHK(host_done, 1'b0)
        `CHK(frame_sync_n_out, 1'b1)
        test_done();
    end
endmodule // afsp_bench
